// ===== sdp_scsi_xfer.v
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "sdp_consts.vh"
module sdp_scsi_xfer #(
	parameter STABLE_CYCLES = `SDP_STABLE_MS * `SDP_CLK_KHZ
) (
	// clock and reset
	input  wire        clk,
	input  wire        reset,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [7:0]  reg_rdata,
	// scsi control lines
	input  wire [7:0]  ctl_in,
	output reg  [7:0]  ctl_out,
	output reg  [7:0]  ctl_oe,
	// scsi data lines
	input  wire [15:0] dat_in,
	output reg  [15:0] dat_out,
	output reg         dat_oe,
	// data fifo
	input  wire [15:0] fifo_rd_data,
	input  wire        fifo_rd_valid,
	output reg         fifo_pop,
	output reg  [15:0] fifo_wr_data,
	output reg         fifo_wr_wide,
	output reg         fifo_push,
	input  wire        fifo_wr_ready,
	// sensing and scam
	input  wire [1:0]  sense_type,
	input  wire        scam_select_done,
	output reg  [1:0]  driver_mode,
	output reg         driver_enable,
	// interrupt
	output reg         bus_interrupt_out
);

	localparam ST_IDLE  = 3'd0;
	localparam ST_IACK  = 3'd1;
	localparam ST_TREQ  = 3'd2;
	localparam ST_THOLD = 3'd3;
	localparam ST_TWAIT = 3'd4;
	localparam ST_PULSE = 3'd5;

	reg [7:0]  transfer_control_0_reg;
	reg [7:0]  bus_signal_out_reg;
	reg [7:0]  data_latch_low_reg;
	reg [7:0]  data_latch_high_reg;
	reg [7:0]  bus_event_mask_0_reg;
	reg [7:0]  bus_event_mask_1_reg;
	reg [7:0]  fifo_transfer_control_reg;
	reg [7:0]  transfer_rate_select_reg;
	reg [7:0]  count_reg;
	reg [2:0]  state_reg;
	reg        pio_ready_flag_reg;
	reg        req_drv_reg;
	reg        ack_drv_reg;
	reg        dat_drv_reg;
	reg        pioen_q_reg;
	reg        req_q_reg;
	reg        driver_mode_change_irq_reg;
	reg        scam_reg;
	reg        atn_reg;
	reg [1:0]  cand_reg;
	reg [31:0] stable_cnt_reg;
	reg        mode_valid_reg;

	wire target   = transfer_control_0_reg[`SDP_X_TARGET];
	wire wide     = transfer_control_0_reg[`SDP_X_WIDE];
	wire pio_en   = transfer_control_0_reg[`SDP_X_PIOEN];
	wire dma_en   = fifo_transfer_control_reg[0];
	wire req_in   = ctl_in[`SDP_C_REQ];
	wire ack_in   = ctl_in[`SDP_C_ACK];
	wire atn_in   = ctl_in[`SDP_C_ATN];
	wire phase_in = target ? bus_signal_out_reg[`SDP_C_IO]
		: ctl_in[`SDP_C_IO];
	wire cmd_ph   = target ? bus_signal_out_reg[`SDP_C_CD]
		: ctl_in[`SDP_C_CD];
	wire wr_datl  = reg_write && reg_addr == `SDP_A_DATL;
	wire rd_datl  = reg_read && reg_addr == `SDP_A_DATL;
	wire clr0_wr  = reg_write && reg_addr == `SDP_A_CLR0;
	wire clr1_wr  = reg_write && reg_addr == `SDP_A_CLR1;
	wire sync_x   = transfer_rate_select_reg[3:0] != 4'h0 && !cmd_ph;
	wire two_byte = transfer_rate_select_reg[7] && count_reg > 8'h01;
	wire [7:0] step = two_byte ? 8'h02 : 8'h01;
	wire sdone    = dma_en && count_reg == 8'h00;
	wire dmadone  = sdone && !fifo_rd_valid;
	wire [7:0] stat0 = {4'h0, driver_mode_change_irq_reg, sdone, pio_ready_flag_reg,
		dmadone};
	wire [7:0] stat1 = {1'b0, atn_reg, 5'h00, scam_reg};
	wire [7:0] sig_drv = {bus_signal_out_reg[7:2], req_drv_reg,
		ack_drv_reg};
	wire auto_on  = pio_en || dma_en;
	// wide receive: the bus high byte is latched together with the low one
	wire hi_load  = wide && pio_en && !dma_en && (target ?
		(!phase_in && state_reg == ST_TREQ && ack_in) :
		(phase_in && state_reg == ST_IDLE && req_in &&
		!pio_ready_flag_reg));
	// drop the drivers in the same cycle that driver_enable falls
	wire drv_on   = driver_enable &&
		!(sense_type != cand_reg && sense_type != driver_mode);

	// register writes
	always @(posedge clk) begin
		if (reset) begin
			transfer_control_0_reg    <= `SDP_RST_BYTE;
			bus_signal_out_reg        <= `SDP_RST_BYTE;
			data_latch_high_reg       <= `SDP_RST_BYTE;
			bus_event_mask_0_reg      <= `SDP_RST_BYTE;
			bus_event_mask_1_reg      <= `SDP_RST_BYTE;
			fifo_transfer_control_reg <= `SDP_RST_BYTE;
			transfer_rate_select_reg  <= `SDP_RST_BYTE;
		end else begin
			if (reg_write) begin
				case (reg_addr)
				`SDP_A_XCTL0: transfer_control_0_reg <= reg_wdata;
				`SDP_A_SIGO:  bus_signal_out_reg <= reg_wdata;
				`SDP_A_DATH:  data_latch_high_reg <= reg_wdata;
				`SDP_A_MASK0: bus_event_mask_0_reg <= reg_wdata;
				`SDP_A_MASK1: bus_event_mask_1_reg <= reg_wdata;
				`SDP_A_DFCTL: fifo_transfer_control_reg <= reg_wdata;
				`SDP_A_RATE:  transfer_rate_select_reg <= reg_wdata;
				default: ;
				endcase
			end
			if (hi_load)
				data_latch_high_reg <= dat_in[15:8];
		end
	end

	// register reads, data one cycle after the strobe
	always @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
			`SDP_A_XCTL0: reg_rdata <= transfer_control_0_reg;
			`SDP_A_SIGO:  reg_rdata <= bus_signal_out_reg;
			`SDP_A_SIGI:  reg_rdata <= ctl_in;
			`SDP_A_DATL:  reg_rdata <= data_latch_low_reg;
			`SDP_A_DATH:  reg_rdata <= data_latch_high_reg;
			`SDP_A_BUSL:  reg_rdata <= dat_in[7:0];
			`SDP_A_BUSH:  reg_rdata <= dat_in[15:8];
			`SDP_A_STAT0: reg_rdata <= stat0;
			`SDP_A_STAT1: reg_rdata <= stat1;
			`SDP_A_MASK0: reg_rdata <= bus_event_mask_0_reg;
			`SDP_A_MASK1: reg_rdata <= bus_event_mask_1_reg;
			`SDP_A_DFCTL: reg_rdata <= fifo_transfer_control_reg;
			`SDP_A_RATE:  reg_rdata <= transfer_rate_select_reg;
			`SDP_A_COUNT: reg_rdata <= count_reg;
			`SDP_A_MODE:  reg_rdata <= {5'h00, driver_enable,
				driver_mode};
			default:      reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// handshake engine for auto pio and dma
	always @(posedge clk) begin
		if (reset) begin
			state_reg          <= ST_IDLE;
			pio_ready_flag_reg <= 1'b0;
			req_drv_reg        <= 1'b0;
			ack_drv_reg        <= 1'b0;
			dat_drv_reg        <= 1'b0;
			data_latch_low_reg <= `SDP_RST_BYTE;
			count_reg          <= `SDP_RST_BYTE;
			pioen_q_reg        <= 1'b0;
			req_q_reg          <= 1'b0;
			fifo_pop           <= 1'b0;
			fifo_push          <= 1'b0;
			fifo_wr_data       <= 16'h0000;
			fifo_wr_wide       <= 1'b0;
			dat_out            <= 16'h0000;
		end else begin
			pioen_q_reg <= pio_en;
			req_q_reg   <= req_in;
			fifo_pop    <= 1'b0;
			fifo_push   <= 1'b0;
			if (reg_write && reg_addr == `SDP_A_COUNT)
				count_reg <= reg_wdata;
			if (!auto_on) begin
				// manual mode: latch registers face the bus directly
				state_reg   <= ST_IDLE;
				req_drv_reg <= bus_signal_out_reg[`SDP_C_REQ];
				ack_drv_reg <= bus_signal_out_reg[`SDP_C_ACK];
				dat_drv_reg <= transfer_control_0_reg[`SDP_X_DDRV];
				pio_ready_flag_reg <= 1'b0;
				dat_out <= {data_latch_high_reg, data_latch_low_reg};
				if (wr_datl)
					data_latch_low_reg <= reg_wdata;
			end else if (dma_en) begin
				case (state_reg)
				ST_IDLE: begin
					ack_drv_reg <= 1'b0;
					if (req_in && count_reg != 8'h00 &&
						(!sync_x || !req_q_reg)) begin
						if (phase_in && fifo_wr_ready) begin
							fifo_push    <= 1'b1;
							fifo_wr_data <= two_byte ? dat_in
								: {8'h00, dat_in[7:0]};
							fifo_wr_wide <= two_byte;
							ack_drv_reg  <= 1'b1;
							count_reg    <= count_reg - step;
							state_reg    <= sync_x ? ST_PULSE
								: ST_IACK;
						end else if (!phase_in && fifo_rd_valid) begin
							fifo_pop    <= 1'b1;
							dat_out     <= two_byte ? fifo_rd_data
								: {8'h00, fifo_rd_data[7:0]};
							dat_drv_reg <= 1'b1;
							ack_drv_reg <= 1'b1;
							count_reg   <= count_reg - step;
							state_reg   <= sync_x ? ST_PULSE : ST_IACK;
						end
					end
				end
				ST_PULSE: begin
					ack_drv_reg <= 1'b0;
					dat_drv_reg <= 1'b0;
					state_reg   <= ST_IDLE;
				end
				ST_IACK: begin
					if (!req_in) begin
						ack_drv_reg <= 1'b0;
						dat_drv_reg <= 1'b0;
						state_reg   <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end else if (!target) begin
				case (state_reg)
				ST_IDLE: begin
					ack_drv_reg <= 1'b0;
					dat_drv_reg <= 1'b0;
					if (!phase_in) begin
						if (req_in && !wr_datl)
							pio_ready_flag_reg <= 1'b1;
						if (wr_datl && (pio_ready_flag_reg || req_in)) begin
							pio_ready_flag_reg <= 1'b0;
							dat_out <= {data_latch_high_reg, reg_wdata};
							data_latch_low_reg <= reg_wdata;
							dat_drv_reg <= 1'b1;
							ack_drv_reg <= 1'b1;
							state_reg   <= ST_IACK;
						end
					end else begin
						if (req_in && !pio_ready_flag_reg) begin
							data_latch_low_reg <= dat_in[7:0];
							pio_ready_flag_reg <= 1'b1;
						end else if (rd_datl && pio_ready_flag_reg) begin
							pio_ready_flag_reg <= 1'b0;
							ack_drv_reg <= 1'b1;
							state_reg   <= ST_IACK;
						end
					end
				end
				ST_IACK: begin
					if (!req_in) begin
						ack_drv_reg <= 1'b0;
						dat_drv_reg <= 1'b0;
						state_reg   <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end else if (!phase_in) begin
				// target receive
				case (state_reg)
				ST_IDLE: begin
					if (!ack_in) begin
						req_drv_reg <= 1'b1;
						state_reg   <= ST_TREQ;
					end
				end
				ST_TREQ: begin
					if (ack_in) begin
						data_latch_low_reg <= dat_in[7:0];
						pio_ready_flag_reg <= 1'b1;
						state_reg <= ST_THOLD;
					end
				end
				ST_THOLD: begin
					if (rd_datl) begin
						pio_ready_flag_reg <= 1'b0;
						req_drv_reg <= 1'b0;
						state_reg   <= ST_TWAIT;
					end
				end
				ST_TWAIT: begin
					if (!ack_in)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
				endcase
			end else begin
				// target send
				case (state_reg)
				ST_IDLE: begin
					if (!pioen_q_reg && !wr_datl)
						pio_ready_flag_reg <= 1'b1;
					if (wr_datl) begin
						pio_ready_flag_reg <= 1'b0;
						data_latch_low_reg <= reg_wdata;
						dat_out <= {data_latch_high_reg, reg_wdata};
						dat_drv_reg <= 1'b1;
						req_drv_reg <= 1'b1;
						state_reg   <= ST_TREQ;
					end
				end
				ST_TREQ: begin
					if (ack_in) begin
						req_drv_reg <= 1'b0;
						state_reg   <= ST_TWAIT;
					end
				end
				ST_TWAIT: begin
					if (!ack_in) begin
						dat_drv_reg <= 1'b0;
						pio_ready_flag_reg <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end
			if (auto_on && !dma_en && !pio_en)
				state_reg <= ST_IDLE;
		end
	end

	// sticky events, atn_reg also clears when atn_in drops; a new event wins over a clear in the same cycle
	always @(posedge clk) begin
		if (reset) begin
			driver_mode_change_irq_reg <= 1'b0;
			scam_reg  <= 1'b0;
			atn_reg   <= 1'b0;
		end else begin
			if (clr0_wr && reg_wdata[`SDP_S0_DRIVER_MODE_CHANGE_IRQ])
				driver_mode_change_irq_reg <= 1'b0;
			if (clr1_wr && reg_wdata[`SDP_S1_SCAM])
				scam_reg <= 1'b0;
			if (!atn_in || (clr1_wr && reg_wdata[`SDP_S1_ATNTARG]))
				atn_reg <= 1'b0;
			if (mode_valid_reg && stable_cnt_reg >= STABLE_CYCLES - 1 &&
				cand_reg != driver_mode)
				driver_mode_change_irq_reg <= 1'b1;
			if (scam_select_done)
				scam_reg <= 1'b1;
			if (target && atn_in && !req_q_reg)
				atn_reg <= 1'b1;
		end
	end

	// interface type sensing and driver mode
	always @(posedge clk) begin
		if (reset) begin
			cand_reg       <= `SDP_RST_MODE;
			stable_cnt_reg <= 32'h0000_0000;
			mode_valid_reg <= 1'b0;
			driver_mode    <= `SDP_RST_MODE;
			driver_enable  <= 1'b0;
		end else if (sense_type != cand_reg) begin
			cand_reg       <= sense_type;
			stable_cnt_reg <= 32'h0000_0000;
			if (sense_type != driver_mode)
				driver_enable <= 1'b0;
		end else if (stable_cnt_reg < STABLE_CYCLES - 1) begin
			stable_cnt_reg <= stable_cnt_reg + 32'h0000_0001;
			if (cand_reg == driver_mode && mode_valid_reg)
				driver_enable <= 1'b1;
		end else begin
			driver_mode    <= cand_reg;
			driver_enable  <= 1'b1;
			mode_valid_reg <= 1'b1;
		end
	end

	// bus drivers and interrupt line
	always @(posedge clk) begin
		if (reset) begin
			ctl_out           <= 8'h00;
			ctl_oe            <= 8'h00;
			dat_oe            <= 1'b0;
			bus_interrupt_out <= 1'b0;
		end else begin
			ctl_out <= sig_drv;
			ctl_oe  <= drv_on ? sig_drv : 8'h00;
			dat_oe  <= drv_on && dat_drv_reg;
			bus_interrupt_out <=
				|(stat0 & bus_event_mask_0_reg) |
				|(stat1 & bus_event_mask_1_reg);
		end
	end

endmodule // sdp_scsi_xfer

// ===== sdp_consts.vh
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH

// register offsets (8-bit index)
`define SDP_A_XCTL0    8'h00
`define SDP_A_SIGO     8'h01
`define SDP_A_SIGI     8'h02
`define SDP_A_DATL     8'h03
`define SDP_A_DATH     8'h04
`define SDP_A_BUSL     8'h05
`define SDP_A_BUSH     8'h06
`define SDP_A_STAT0    8'h07
`define SDP_A_STAT1    8'h08
`define SDP_A_MASK0    8'h09
`define SDP_A_MASK1    8'h0a
`define SDP_A_CLR0     8'h0b
`define SDP_A_CLR1     8'h0c
`define SDP_A_DFCTL    8'h0d
`define SDP_A_RATE     8'h0e
`define SDP_A_COUNT    8'h0f
`define SDP_A_MODE     8'h10

// transfer_control_0 fields
`define SDP_X_TARGET   0
`define SDP_X_WIDE     1
`define SDP_X_DDRV     2
`define SDP_X_PIOEN    3

// bus control line positions (signal in/out layout)
`define SDP_C_ACK      0
`define SDP_C_REQ      1
`define SDP_C_ATN      4
`define SDP_C_IO       6
`define SDP_C_CD       7

// status bit positions
`define SDP_S0_DMADONE 0
`define SDP_S0_PIORDY  1
`define SDP_S0_SDONE   2
`define SDP_S0_DRIVER_MODE_CHANGE_IRQ   3
`define SDP_S1_SCAM    0
`define SDP_S1_ATNTARG 6

// reset values
`define SDP_RST_BYTE   8'h00
`define SDP_RST_MODE   2'h0

// sense stability time
`define SDP_STABLE_MS  100
`define SDP_CLK_KHZ    50000

`endif

// ===== sdp_xfer_checker.sv
`timescale 1ns/10ps
module sdp_xfer_checker #(
	parameter STABLE_CYCLES = 8
) (
	// clock and reset
	input wire       clk,
	input wire       reset,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_write,
	input wire       reg_read,
	input wire [7:0] reg_rdata,
	// bus and sensing
	input wire [7:0] ctl_in,
	input wire [7:0] ctl_out,
	input wire [7:0] ctl_oe,
	input wire       dat_oe,
	input wire [1:0] sense_type,
	input wire [1:0] driver_mode,
	input wire       driver_enable,
	// interrupt
	input wire       bus_interrupt_out
);
	reg  [7:0]  xctl_reg;
	reg  [7:0]  sigo_reg;
	reg  [15:0] mask_reg;
	reg  [1:0]  sense_reg;
	reg  [31:0] stab_reg;
	wire [7:0]  drv = ctl_out & ctl_oe;
	wire        ipio = xctl_reg[3] & ~xctl_reg[0];
	wire        wr_dat = reg_write && reg_addr == 8'h03;
	wire        tgo = reg_write && reg_addr == 8'h00 && reg_wdata[3] &&
		reg_wdata[0];
	// shadow of the control registers and a sense stability count
	always @(posedge clk) begin
		sense_reg <= sense_type;
		if (reset) begin
			xctl_reg <= 8'h00;
			sigo_reg <= 8'h00;
			mask_reg <= 16'h0000;
			stab_reg <= 32'h0;
		end else begin
			stab_reg <= (sense_type == sense_reg) ? stab_reg + 32'h1 : 32'h0;
			if (reg_write && reg_addr == 8'h00)
				xctl_reg <= reg_wdata;
			if (reg_write && reg_addr == 8'h01)
				sigo_reg <= reg_wdata;
			if (reg_write && reg_addr == 8'h09)
				mask_reg[7:0] <= reg_wdata;
			if (reg_write && reg_addr == 8'h0a)
				mask_reg[15:8] <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_rdata_idle:
	assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_irq_masked:
	assert property ((mask_reg == 16'h0) && $past(mask_reg == 16'h0)
		|-> !bus_interrupt_out)
		else $error("interrupt with all masks clear");
	a_drv_off:
	assert property (!driver_enable |-> ctl_oe == 8'h00 && !dat_oe)
		else $error("bus driven while drivers disabled");
	a_mode_wait:
	assert property (driver_mode != $past(driver_mode)
		|-> stab_reg >= STABLE_CYCLES - 2)
		else $error("driver mode switched before sense settled");
	a_ack_release:
	assert property (ipio && drv[0] && !ctl_in[1] |-> ##[1:3] !drv[0])
		else $error("ack held after req fell");
	a_ack_write:
	assert property (ipio && wr_dat && ctl_in[1] && !ctl_in[6] &&
		driver_enable |-> ##[1:3] drv[0])
		else $error("no ack after data write");
	a_req_enable:
	assert property (tgo && !sigo_reg[6] && !ctl_in[0] && driver_enable
		|-> ##[1:3] drv[1])
		else $error("no req after target receive enable");
	a_req_write:
	assert property (xctl_reg[3] && xctl_reg[0] && sigo_reg[6] && wr_dat &&
		!ctl_in[0] && driver_enable |-> ##[1:3] drv[1])
		else $error("no req after target send write");
endmodule // sdp_xfer_checker

bind sdp_scsi_xfer sdp_xfer_checker #(.STABLE_CYCLES(STABLE_CYCLES)) u_chk (
	.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .dat_oe(dat_oe),
	.sense_type(sense_type), .driver_mode(driver_mode),
	.driver_enable(driver_enable), .bus_interrupt_out(bus_interrupt_out));

// ===== sdp_bus_model.sv
`timescale 1ns/10ps
module sdp_bus_model (
	// clock and reset
	input  wire        clk,
	input  wire        reset,
	// bench control
	input  wire        act_initiator,
	input  wire [7:0]  phase_lines,
	input  wire        req_go,
	input  wire [15:0] tx_word,
	input  wire [3:0]  lag,
	// device side
	input  wire [7:0]  ctl_out,
	input  wire [7:0]  ctl_oe,
	input  wire [15:0] dat_out,
	input  wire        dat_oe,
	output wire [7:0]  ctl_in,
	output wire [15:0] dat_in,
	// observed traffic
	output reg  [15:0] rx_word,
	output reg  [7:0]  xfer_count
);
	reg        req_reg;
	reg        ack_reg;
	reg        pend_reg;
	reg  [3:0] wait_reg;
	wire [7:0] dev = ctl_out & ctl_oe;
	wire       mine = act_initiator ? ack_reg : req_reg;
	// wired-or bus; undriven data shows tx_word while mine is up, its inverse otherwise, so stale values fail
	assign ctl_in = dev | phase_lines | {6'h00, req_reg, ack_reg};
	assign dat_in = dat_oe ? dat_out : (mine ? tx_word : ~tx_word);
	always @(posedge clk) begin
		if (reset) begin
			req_reg <= 1'b0;
			ack_reg <= 1'b0;
			pend_reg <= 1'b0;
			wait_reg <= 4'h0;
			rx_word <= 16'h0000;
			xfer_count <= 8'h00;
		end else begin
			if (req_go)
				pend_reg <= 1'b1;
			if (wait_reg != 4'h0)
				wait_reg <= wait_reg - 4'h1;
			else if (!act_initiator) begin
				// target: req held until ack, then dropped
				if (pend_reg && !req_reg && !dev[0]) begin
					req_reg <= 1'b1;
					pend_reg <= 1'b0;
				end else if (req_reg && dev[0]) begin
					req_reg <= 1'b0;
					rx_word <= dat_in;
					xfer_count <= xfer_count + 8'h01;
					wait_reg <= lag;
				end
			end else begin
				// initiator: ack held until req drops
				if (dev[1] && !ack_reg) begin
					ack_reg <= 1'b1;
					rx_word <= dat_in;
					wait_reg <= lag;
				end else if (ack_reg && !dev[1]) begin
					ack_reg <= 1'b0;
					xfer_count <= xfer_count + 8'h01;
					wait_reg <= lag;
				end
			end
		end
	end
endmodule // sdp_bus_model

// ===== sdp_scsi_xfer_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
	checks_done = checks_done + 1; \
	if ((g) !== (e)) begin \
		fails = fails + 1; \
		$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); \
	end \
end
module sdp_scsi_xfer_test;
	reg         clk, reset, reg_write, reg_read, scam, act_ini, go;
	reg  [7:0]  reg_addr, reg_wdata, phase, rdd;
	reg  [1:0]  sense;
	reg  [15:0] tx;
	reg  [3:0]  lag;
	wire [7:0]  reg_rdata, ctl_in, ctl_out, ctl_oe, nx;
	wire [15:0] dat_in, dat_out, rx;
	wire [1:0]  dmode;
	wire        dat_oe, den, irq;
	integer     fails = 0, checks_done = 0, cycles = 0;

	sdp_scsi_xfer #(.STABLE_CYCLES(8)) DUT (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .dat_in(dat_in),
		.dat_out(dat_out), .dat_oe(dat_oe), .fifo_rd_data(16'h0000),
		.fifo_rd_valid(1'b0), .fifo_pop(), .fifo_wr_data(), .fifo_wr_wide(),
		.fifo_push(), .fifo_wr_ready(1'b1), .sense_type(sense),
		.scam_select_done(scam), .driver_mode(dmode), .driver_enable(den),
		.bus_interrupt_out(irq));
	sdp_bus_model u_bus (.clk(clk), .reset(reset), .act_initiator(act_ini),
		.phase_lines(phase), .req_go(go), .tx_word(tx), .lag(lag),
		.ctl_out(ctl_out), .ctl_oe(ctl_oe), .dat_out(dat_out), .dat_oe(dat_oe),
		.ctl_in(ctl_in), .dat_in(dat_in), .rx_word(rx), .xfer_count(nx));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", checks_done, fails);
			if (fails == 0 && checks_done > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			report_and_stop;
		end
	end
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_write <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk);
			reg_write <= 1'b0;
		end
	endtask
	task rd_raw(input [7:0] a);
		begin
			@(posedge clk);
			reg_read <= 1'b1;
			reg_addr <= a;
			@(posedge clk);
			reg_read <= 1'b0;
			#1;
			rdd = reg_rdata;
		end
	endtask
	task rd(input [7:0] a, input [7:0] m, input [7:0] e);
		begin
			rd_raw(a);
			`CHK(rdd & m, e)
		end
	endtask
	task pl(input [7:0] a, input [7:0] m, input [7:0] e);
		integer n;
		begin
			n = 0;
			rd_raw(a);
			while ((rdd & m) !== e && n < 60) begin
				rd_raw(a);
				n = n + 1;
			end
			`CHK(rdd & m, e)
		end
	endtask
	task wx(input [7:0] n);
		integer k;
		begin
			k = 0;
			while (nx !== n && k < 200) begin
				@(posedge clk);
				k = k + 1;
			end
			`CHK(nx, n)
		end
	endtask
	task kick;
		begin
			@(posedge clk);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
		end
	endtask

	initial begin
		reset = 1'b1;
		{reg_write, reg_read, scam, act_ini, go} = 5'h00;
		{reg_addr, reg_wdata, phase} = 24'h000000;
		sense = 2'h1;
		tx = 16'h0000;
		lag = 4'h0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rd(8'h07, 8'hff, 8'h00);
		rd(8'h20, 8'hff, 8'h00);
		repeat (16) @(posedge clk);
		rd(8'h10, 8'h07, 8'h05);
		wr(8'h09, 8'h08);
		@(posedge clk);
		sense <= 2'h2;
		repeat (24) @(posedge clk);
		rd(8'h07, 8'h08, 8'h08);
		`CHK(irq, 1'b1)
		rd(8'h10, 8'h07, 8'h06);
		wr(8'h0b, 8'h08);
		rd(8'h07, 8'h08, 8'h00);
		`CHK(irq, 1'b0)
		wr(8'h09, 8'h00);
		@(posedge clk);
		scam <= 1'b1;
		@(posedge clk);
		scam <= 1'b0;
		rd(8'h08, 8'h01, 8'h01);
		`CHK(irq, 1'b0)
		wr(8'h0a, 8'h01);
		rd(8'h08, 8'h01, 8'h01);
		`CHK(irq, 1'b1)
		wr(8'h0c, 8'h01);
		rd(8'h08, 8'h01, 8'h00);
		`CHK(irq, 1'b0)
		wr(8'h0a, 8'h00);
		// manual mode: registers drive the lines directly
		wr(8'h01, 8'h01);
		repeat (2) @(posedge clk);
		rd(8'h02, 8'h01, 8'h01);
		wr(8'h00, 8'h04);
		wr(8'h03, 8'h5c);
		rd(8'h05, 8'hff, 8'h5c);
		wr(8'h01, 8'h00);
		// initiator, wide data out
		wr(8'h00, 8'h0a);
		kick;
		pl(8'h07, 8'h02, 8'h02);
		wr(8'h04, 8'h12);
		wr(8'h03, 8'ha5);
		wx(8'h01);
		`CHK(rx, 16'h12a5)
		rd(8'h07, 8'h02, 8'h00);
		// initiator data in, slow target
		phase <= 8'h40;
		tx <= 16'h9c3c;
		lag <= 4'h5;
		kick;
		pl(8'h07, 8'h02, 8'h02);
		rd(8'h04, 8'hff, 8'h9c);
		rd(8'h03, 8'hff, 8'h3c);
		wx(8'h02);
		rd(8'h07, 8'h02, 8'h00);
		// target receive
		phase <= 8'h00;
		act_ini <= 1'b1;
		tx <= 16'h005a;
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h09);
		pl(8'h07, 8'h02, 8'h02);
		rd(8'h03, 8'hff, 8'h5a);
		tx <= 16'h00c3;
		wx(8'h03);
		pl(8'h07, 8'h02, 8'h02);
		wr(8'h00, 8'h01);
		rd(8'h03, 8'hff, 8'hc3);
		wx(8'h04);
		repeat (20) @(posedge clk);
		`CHK(nx, 8'h04)
		// target send
		wr(8'h01, 8'h40);
		wr(8'h00, 8'h09);
		rd(8'h07, 8'h02, 8'h02);
		wr(8'h03, 8'h77);
		wx(8'h05);
		`CHK(rx[7:0], 8'h77)
		pl(8'h07, 8'h02, 8'h02);
		wr(8'h00, 8'h00);
		// dma in, wide, odd count of three bytes
		wr(8'h01, 8'h00);
		phase <= 8'h40;
		act_ini <= 1'b0;
		lag <= 4'h0;
		wr(8'h0e, 8'h80);
		wr(8'h0f, 8'h03);
		wr(8'h0d, 8'h01);
		kick;
		wx(8'h06);
		rd(8'h0f, 8'hff, 8'h01);
		kick;
		wx(8'h07);
		rd(8'h0f, 8'hff, 8'h00);
		rd(8'h07, 8'h05, 8'h05);
		wr(8'h0d, 8'h00);
		report_and_stop;
	end
endmodule // sdp_scsi_xfer_test
